// ==== inc/dtc_pkg.sv ====
// Package for the dual timer/counter with external interrupt detectors.
// Assumes an AXI4-Lite master with 32-bit data; offsets are register indices,
// and a register's byte address is four times its index.
package dtc_pkg;

    localparam int          ADDR_W        = 10;
    localparam logic [7:0]  OFF_CONTROL   = 8'h88;
    localparam logic [7:0]  OFF_MODE      = 8'h89;
    localparam logic [7:0]  OFF_ZERO_LOW  = 8'h8a;
    localparam logic [7:0]  OFF_ONE_LOW   = 8'h8b;
    localparam logic [7:0]  OFF_ZERO_HIGH = 8'h8c;
    localparam logic [7:0]  OFF_ONE_HIGH  = 8'h8d;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h90;
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h94;

    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    // Control register field positions
    localparam int CTL_T1_FLAG  = 7;
    localparam int CTL_T1_RUN   = 6;
    localparam int CTL_T0_FLAG  = 5;
    localparam int CTL_T0_RUN   = 4;
    localparam int CTL_X1_FLAG  = 3;
    localparam int CTL_X1_TYPE  = 2;
    localparam int CTL_X0_FLAG  = 1;
    localparam int CTL_X0_TYPE  = 0;

    // Mode register field positions (timer one in high nibble)
    localparam int MOD_T1_GATE  = 7;
    localparam int MOD_T1_SEL   = 6;
    localparam int MOD_T1_LSB   = 4;
    localparam int MOD_T0_GATE  = 3;
    localparam int MOD_T0_SEL   = 2;
    localparam int MOD_T0_LSB   = 0;

    localparam int          PRESCALE_W    = 5;
    localparam logic [4:0]  PRESCALE_TOP  = 5'h1f;
    localparam logic [7:0]  BYTE_TOP      = 8'hff;

    // Status and mask bit positions
    localparam int IRQ_T0 = 0;
    localparam int IRQ_T1 = 1;
    localparam int IRQ_X0 = 2;
    localparam int IRQ_X1 = 3;
    localparam int IRQ_N  = 4;

    typedef enum logic [1:0] {
        MODE_PRESCALED,
        MODE_SIXTEEN,
        MODE_RELOAD,
        MODE_SPLIT
    } dtc_mode_t;

    // Vector acknowledge from the CPU interrupt logic
    typedef struct packed {
        logic t1;
        logic t0;
        logic x1;
        logic x0;
    } dtc_ack_t;

endpackage : dtc_pkg

// ==== hdl/dtc_top.sv ====
// Dual 16-bit timer/counter with two external interrupt detectors, AXI4-Lite slave.
// Assumes pins are asynchronous to CLK; ACK pulses come from the CPU vector logic.
//
// Summary of operation
// (R1) Timer one runs only while its run bit set
// (R2) Timer zero runs only while its run bit set; in mode 11 its high byte runs on timer one's run bit
// (R3) Timer one overflow sets flag, vector clears it
// (R4) Timer zero overflow sets flag, vector clears it
// (R5) Pin one falling edge sets flag, vector clears
// (R6) Pin zero falling edge sets flag, vector clears
// (R7) Pin one type: 0 low level, 1 edge
// (R8) Pin zero type: 0 low level, 1 edge
// (R9) Timer one gate needs pin one high
// (R10) Timer zero gate needs pin zero high
// (R11) Timer one: every 2 clocks or pin edge
// (R12) Timer zero: every 2 clocks or pin edge
// (R13) Mode 00 prescaled 8-bit, mode 01 16-bit
// (R14) Mode 10 low byte reloads from high byte
// (R15) Mode 11 splits timer zero, timer one stops
// (R16) Count bytes read/write separately, reset zero
// (R17) Prescaler wrap bumps high byte, wrap flags
// (R18) Pins synchronised, falling edges from samples
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module dtc_top
    import dtc_pkg::*;
(
    input  wire logic              CLK,      // System clock, 20 MHz
    input  wire logic              RST,      // Synchronous reset, active high
    input  wire logic [ADDR_W-1:0] AWADDR,   // Write address
    input  wire logic              AWVALID,  // Write address valid
    output logic                   AWREADY,  // Write address ready
    input  wire logic [31:0]       WDATA,    // Write data
    input  wire logic [3:0]        WSTRB,    // Write strobes
    input  wire logic              WVALID,   // Write data valid
    output logic                   WREADY,   // Write data ready
    output logic [1:0]             BRESP,    // Write response
    output logic                   BVALID,   // Write response valid
    input  wire logic              BREADY,   // Write response ready
    input  wire logic [ADDR_W-1:0] ARADDR,   // Read address
    input  wire logic              ARVALID,  // Read address valid
    output logic                   ARREADY,  // Read address ready
    output logic [31:0]            RDATA,    // Read data
    output logic [1:0]             RRESP,    // Read response
    output logic                   RVALID,   // Read data valid
    input  wire logic              RREADY,   // Read data ready
    input  wire logic              EXT_IRQ_PIN_ZERO, // Interrupt pin zero
    input  wire logic              EXT_IRQ_PIN_ONE,  // Interrupt pin one
    input  wire logic              COUNT_PIN_ZERO,   // Count pin zero
    input  wire logic              COUNT_PIN_ONE,    // Count pin one
    input  wire dtc_ack_t          VECTOR_ACK,       // CPU vectored, one pulse each
    output logic                   EXT_IRQ_ZERO_REQ, // Pin zero interrupt request
    output logic                   EXT_IRQ_ONE_REQ,  // Pin one interrupt request
    output logic                   IRQ               // Masked status interrupt
);

    logic [7:0]       control;
    logic [7:0]       mode;
    logic [7:0]       zero_low, zero_high, one_low, one_high;
    logic [IRQ_N-1:0] irq_stat, irq_mask;
    logic [3:0]       sync1, sync2, prev;
    logic             half;
    logic             aw_held, w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;

    dtc_mode_t m0, m1;
    assign m0 = dtc_mode_t'(mode[MOD_T0_LSB +: 2]);
    assign m1 = dtc_mode_t'(mode[MOD_T1_LSB +: 2]);

    // Pin synchronisers; bit order x0, x1, c0, c1
    always_ff @(posedge CLK) begin
        if (RST) begin
            sync1 <= 4'hf;                                     // Idle-high pins, no false event
            sync2 <= 4'hf;
            prev  <= 4'hf;
        end else begin
            sync1 <= {COUNT_PIN_ONE, COUNT_PIN_ZERO, EXT_IRQ_PIN_ONE, EXT_IRQ_PIN_ZERO};
            sync2 <= sync1;                                    // see (R18)
            prev  <= sync2;
        end
    end

    logic [3:0] fall;
    assign fall = prev & ~sync2;                               // see (R18)

    // Half-rate tick for timer mode
    always_ff @(posedge CLK) begin
        if (RST) begin
            half <= 1'b0;
        end else begin
            half <= ~half;
        end
    end

    logic run0, run1, tick0, tick1, tick0h;
    assign run0 = control[CTL_T0_RUN] & (~mode[MOD_T0_GATE] | sync2[0]); // see (R2) (R10)
    assign run1 = control[CTL_T1_RUN] & (~mode[MOD_T1_GATE] | sync2[1]); // see (R1) (R9)
    assign tick0 = run0 & (mode[MOD_T0_SEL] ? fall[2] : half);          // see (R12)
    assign tick1 = run1 & (mode[MOD_T1_SEL] ? fall[3] : half) & (m1 != MODE_SPLIT); // see (R11) (R15)
    assign tick0h = control[CTL_T1_RUN] & half;                         // see (R15)

    // AXI write decode; byte address is four times the register index
    logic [7:0] aw_idx, ar_idx;
    assign aw_idx = (aw_addr[1:0] == 2'b00) ? aw_addr[ADDR_W-1:2] : 8'h00; // Unaligned: unmapped
    assign ar_idx = (ARADDR[1:0] == 2'b00) ? ARADDR[ADDR_W-1:2] : 8'h00;
    logic wr_go;
    assign wr_go = aw_held & w_held & ~BVALID;
    logic wr_ctl, wr_mod, wr_z0, wr_z1, wr_o0, wr_o1, wr_st, wr_mk;
    assign wr_ctl = wr_go & w_strb[0] & (aw_idx == OFF_CONTROL);
    assign wr_mod = wr_go & w_strb[0] & (aw_idx == OFF_MODE);
    assign wr_z0  = wr_go & w_strb[0] & (aw_idx == OFF_ZERO_LOW);
    assign wr_z1  = wr_go & w_strb[0] & (aw_idx == OFF_ZERO_HIGH);
    assign wr_o0  = wr_go & w_strb[0] & (aw_idx == OFF_ONE_LOW);
    assign wr_o1  = wr_go & w_strb[0] & (aw_idx == OFF_ONE_HIGH);
    assign wr_st  = wr_go & w_strb[0] & (aw_idx == OFF_IRQ_STAT);
    assign wr_mk  = wr_go & w_strb[0] & (aw_idx == OFF_IRQ_MASK);

    // Timer zero counting
    logic ovf0, ovf0h;
    always_ff @(posedge CLK) begin
        if (RST) begin
            zero_low  <= RST_BYTE;                              // see (R16)
            zero_high <= RST_BYTE;
            ovf0      <= 1'b0;
            ovf0h     <= 1'b0;
        end else begin
            ovf0  <= 1'b0;
            ovf0h <= 1'b0;
            if (tick0) begin
                case (m0)
                    MODE_PRESCALED: begin                       // see (R13) (R17)
                        zero_low[PRESCALE_W-1:0] <= zero_low[PRESCALE_W-1:0] + 5'h01;
                        if (zero_low[PRESCALE_W-1:0] == PRESCALE_TOP) begin
                            zero_high <= zero_high + 8'h01;
                            ovf0      <= (zero_high == BYTE_TOP);
                        end
                    end
                    MODE_SIXTEEN: begin                         // see (R13)
                        {zero_high, zero_low} <= {zero_high, zero_low} + 16'h0001;
                        ovf0 <= ({zero_high, zero_low} == {BYTE_TOP, BYTE_TOP});
                    end
                    MODE_RELOAD: begin                          // see (R14)
                        zero_low <= (zero_low == BYTE_TOP) ? zero_high : zero_low + 8'h01;
                        ovf0     <= (zero_low == BYTE_TOP);
                    end
                    MODE_SPLIT: begin                           // see (R15)
                        zero_low <= zero_low + 8'h01;
                        ovf0     <= (zero_low == BYTE_TOP);
                    end
                    default: ;
                endcase
            end
            if (m0 == MODE_SPLIT && tick0h) begin               // see (R15)
                zero_high <= zero_high + 8'h01;
                ovf0h     <= (zero_high == BYTE_TOP);
            end
            if (wr_z0) zero_low  <= w_data[7:0];                // see (R16)
            if (wr_z1) zero_high <= w_data[7:0];
        end
    end

    // Timer one counting
    logic ovf1;
    always_ff @(posedge CLK) begin
        if (RST) begin
            one_low  <= RST_BYTE;                               // see (R16)
            one_high <= RST_BYTE;
            ovf1     <= 1'b0;
        end else begin
            ovf1 <= 1'b0;
            if (tick1) begin
                case (m1)
                    MODE_PRESCALED: begin                       // see (R13) (R17)
                        one_low[PRESCALE_W-1:0] <= one_low[PRESCALE_W-1:0] + 5'h01;
                        if (one_low[PRESCALE_W-1:0] == PRESCALE_TOP) begin
                            one_high <= one_high + 8'h01;
                            ovf1     <= (one_high == BYTE_TOP);
                        end
                    end
                    MODE_SIXTEEN: begin
                        {one_high, one_low} <= {one_high, one_low} + 16'h0001;
                        ovf1 <= ({one_high, one_low} == {BYTE_TOP, BYTE_TOP});
                    end
                    MODE_RELOAD: begin                          // see (R14)
                        one_low <= (one_low == BYTE_TOP) ? one_high : one_low + 8'h01;
                        ovf1    <= (one_low == BYTE_TOP);
                    end
                    default: ;
                endcase
            end
            if (wr_o0) one_low  <= w_data[7:0];
            if (wr_o1) one_high <= w_data[7:0];
        end
    end

    // Control register: flags set by hardware, set wins over clear
    logic set_x0, set_x1;
    assign set_x0 = control[CTL_X0_TYPE] ? fall[0] : ~sync2[0]; // see (R6) (R8)
    assign set_x1 = control[CTL_X1_TYPE] ? fall[1] : ~sync2[1]; // see (R5) (R7)
    logic [7:0] next_control;
    always_comb begin
        next_control = wr_ctl ? w_data[7:0] : control;
        if (VECTOR_ACK.t1) next_control[CTL_T1_FLAG] = 1'b0;
        if (VECTOR_ACK.t0) next_control[CTL_T0_FLAG] = 1'b0;
        if (VECTOR_ACK.x1) next_control[CTL_X1_FLAG] = 1'b0;
        if (VECTOR_ACK.x0) next_control[CTL_X0_FLAG] = 1'b0;
        if (ovf1 | ovf0h) next_control[CTL_T1_FLAG] = 1'b1;     // see (R3) (R15)
        if (ovf0)         next_control[CTL_T0_FLAG] = 1'b1;     // see (R4)
        if (set_x1)       next_control[CTL_X1_FLAG] = 1'b1;     // see (R5)
        if (set_x0)       next_control[CTL_X0_FLAG] = 1'b1;     // see (R6)
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            control <= RST_BYTE;
            mode    <= RST_BYTE;
        end else begin
            control <= next_control;
            if (wr_mod) mode <= w_data[7:0];
        end
    end

    // Sticky status, write one to clear, mask gates IRQ
    logic [IRQ_N-1:0] ev;
    assign ev = {set_x1, set_x0, ovf1 | ovf0h, ovf0};
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_stat <= '0;
            irq_mask <= '0;
            IRQ      <= 1'b0;
            EXT_IRQ_ZERO_REQ <= 1'b0;
            EXT_IRQ_ONE_REQ  <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_st ? w_data[IRQ_N-1:0] : '0)) | ev;
            if (wr_mk) irq_mask <= w_data[IRQ_N-1:0];
            IRQ <= |(irq_stat & irq_mask);
            EXT_IRQ_ZERO_REQ <= control[CTL_X0_FLAG];
            EXT_IRQ_ONE_REQ  <= control[CTL_X1_FLAG];
        end
    end

    // AXI write channel
    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
            AWREADY <= 1'b0;
            WREADY  <= 1'b0;
            BVALID  <= 1'b0;
            BRESP   <= RESP_OKAY;
        end else begin
            AWREADY <= ~aw_held & ~(AWVALID & AWREADY);
            WREADY  <= ~w_held & ~(WVALID & WREADY);
            if (AWVALID & AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= AWADDR;
            end
            if (WVALID & WREADY) begin
                w_held <= 1'b1;
                w_data <= WDATA;
                w_strb <= WSTRB;
            end
            if (wr_go) begin
                BVALID  <= 1'b1;
                BRESP   <= mapped(aw_idx) ? RESP_OKAY : RESP_SLVERR;
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                AWREADY <= 1'b0;
                WREADY  <= 1'b0;
            end
            if (BVALID & BREADY) BVALID <= 1'b0;
        end
    end

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFF_CONTROL) || (a == OFF_MODE) || (a == OFF_ZERO_LOW)
              || (a == OFF_ONE_LOW) || (a == OFF_ZERO_HIGH) || (a == OFF_ONE_HIGH)
              || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
    endfunction : mapped

    // AXI read channel
    logic [7:0] rd_byte;
    always_comb begin
        case (ar_idx)
            OFF_CONTROL:   rd_byte = control;
            OFF_MODE:      rd_byte = mode;
            OFF_ZERO_LOW:  rd_byte = zero_low;
            OFF_ONE_LOW:   rd_byte = one_low;
            OFF_ZERO_HIGH: rd_byte = zero_high;
            OFF_ONE_HIGH:  rd_byte = one_high;
            OFF_IRQ_STAT:  rd_byte = {4'h0, irq_stat};
            OFF_IRQ_MASK:  rd_byte = {4'h0, irq_mask};
            default:       rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= 32'h0000_0000;
            RRESP   <= RESP_OKAY;
        end else begin
            ARREADY <= ~RVALID & ~(ARVALID & ARREADY);
            if (ARVALID & ARREADY) begin
                RVALID  <= 1'b1;
                ARREADY <= 1'b0;
                RDATA   <= {24'h00_0000, rd_byte};
                RRESP   <= mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
            end else if (RVALID & RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end

    // Checks
    a_halt_zero: assert property (@(posedge CLK) disable iff (RST) // see (R2)
        !control[CTL_T0_RUN] && !wr_z0 && !wr_z1 && m0 != MODE_SPLIT
        |=> $stable(zero_low) && $stable(zero_high))
        else $error("timer zero moved while halted");
    a_halt_one: assert property (@(posedge CLK) disable iff (RST) // see (R1)
        !control[CTL_T1_RUN] && !wr_o0 && !wr_o1 |=> $stable({one_high, one_low}))
        else $error("timer one moved while halted");
    a_flag_zero: assert property (@(posedge CLK) disable iff (RST) // see (R4)
        ovf0 |=> control[CTL_T0_FLAG])
        else $error("timer zero flag not set");
    a_flag_one: assert property (@(posedge CLK) disable iff (RST) // see (R3)
        ovf1 |=> control[CTL_T1_FLAG])
        else $error("timer one flag not set");
    a_ack_clear: assert property (@(posedge CLK) disable iff (RST) // see (R4)
        VECTOR_ACK.t0 && !ovf0 && !wr_ctl |=> !control[CTL_T0_FLAG])
        else $error("vector did not clear flag");
    a_edge_x1: assert property (@(posedge CLK) disable iff (RST) // see (R5)
        control[CTL_X1_TYPE] && fall[1] |=> control[CTL_X1_FLAG])
        else $error("pin one edge missed");
    a_level_x0: assert property (@(posedge CLK) disable iff (RST) // see (R8)
        !control[CTL_X0_TYPE] && !sync2[0] |=> control[CTL_X0_FLAG])
        else $error("pin zero level missed");
    a_gate_one: assert property (@(posedge CLK) disable iff (RST) // see (R9)
        mode[MOD_T1_GATE] && !sync2[1] |-> !tick1)
        else $error("gated timer one ticked");
    a_rate_zero: assert property (@(posedge CLK) disable iff (RST) // see (R12)
        tick0 && !mode[MOD_T0_SEL] |=> !tick0 || mode[MOD_T0_SEL])
        else $error("timer zero ticked faster than half rate");
    a_split_stop: assert property (@(posedge CLK) disable iff (RST) // see (R15)
        m1 == MODE_SPLIT |-> !tick1)
        else $error("timer one ran in mode 11");
    a_reload: assert property (@(posedge CLK) disable iff (RST) // see (R14)
        tick0 && m0 == MODE_RELOAD && zero_low == BYTE_TOP && !wr_z0 && !wr_z1
        |=> zero_low == $past(zero_high))
        else $error("reload value wrong");
    a_sync_edge: assert property (@(posedge CLK) disable iff (RST) // see (R18)
        fall[2] |-> !$past(COUNT_PIN_ZERO, 2) && $past(COUNT_PIN_ZERO, 3))
        else $error("edge without pin fall");

    c_ovf0: cover property (@(posedge CLK) disable iff (RST) ovf0);
    c_split: cover property (@(posedge CLK) disable iff (RST) ovf0h);
    c_edge1: cover property (@(posedge CLK) disable iff (RST) fall[1] && control[CTL_X1_TYPE]);
    c_irq: cover property (@(posedge CLK) disable iff (RST) IRQ);

endmodule : dtc_top

// ==== bench/dtc_partner.sv ====
// Far-side model: count pins, interrupt pins and CPU vector acknowledge.
// Assumes its tasks are called right after a rising edge of clk.
`timescale 1ns/1ps
module dtc_partner
    import dtc_pkg::*;
(
    input  wire logic clk,     // System clock
    output logic [1:0] irq_pin, // Interrupt pins, pulled up when idle
    output logic [1:0] cnt_pin, // Count pins, pulled up when idle
    output dtc_ack_t   vec_ack  // Vector acknowledge pulses
);
    initial begin
        irq_pin = 2'h3;
        cnt_pin = 2'h3;
        vec_ack = '0;
    end

    // Each level held long enough to pass the synchroniser
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            cnt_pin[i] <= 1'b0;
            repeat (4) @(posedge clk);
            cnt_pin[i] <= 1'b1;
            repeat (4) @(posedge clk);
        end
    endtask : pulse

    task automatic level(input int i, input logic v, input int hold);
        irq_pin[i] <= v;
        repeat (hold) @(posedge clk);
    endtask : level

    task automatic ack(input dtc_ack_t a);
        vec_ack <= a;
        @(posedge clk);
        vec_ack <= '0;
        @(posedge clk);
    endtask : ack
endmodule : dtc_partner

// ==== bench/testbench.sv ====
// Self-checking bench: AXI4-Lite master, pin model, response scoreboard.
// Assumes registers at four times their index and pins idle high.
`timescale 1ns/1ps
module testbench
    import dtc_pkg::*;
();
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic              awvalid, wvalid, bready, arvalid, rready;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp, irq_pin, cnt_pin;
    logic              irq, req0, req1;
    dtc_ack_t          vec_ack, ak;
    logic [34:0]       exp_q[$];
    logic [34:0]       exp_e;
    int                failures = 0;
    int                compares = 0;
    int                seed = 32'hf436;
    int                i, sh;
    logic [7:0]        lo, hi, run, flg, typ, rb;
    logic [7:0]        cnt_off[4] = '{OFF_ZERO_LOW, OFF_ONE_LOW, OFF_ZERO_HIGH, OFF_ONE_HIGH};

    always #25 clk = ~clk;

    dtc_top u_dtc_top (
        .CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
        .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
        .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .EXT_IRQ_PIN_ZERO(irq_pin[0]), .EXT_IRQ_PIN_ONE(irq_pin[1]),
        .COUNT_PIN_ZERO(cnt_pin[0]), .COUNT_PIN_ONE(cnt_pin[1]), .VECTOR_ACK(vec_ack),
        .EXT_IRQ_ZERO_REQ(req0), .EXT_IRQ_ONE_REQ(req1), .IRQ(irq)
    );

    dtc_partner u_dtc_partner (
        .clk(clk), .irq_pin(irq_pin), .cnt_pin(cnt_pin), .vec_ack(vec_ack)
    );

    task automatic complete_run();
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic fail(input string m);
        failures++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail

    task automatic chk(input logic g, input logic e);
        compares++;
        if (g !== e) fail("output level mismatch");
    endtask : chk

    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a inside {OFF_CONTROL, OFF_MODE, OFF_ZERO_LOW, OFF_ONE_LOW, OFF_ZERO_HIGH,
                          OFF_ONE_HIGH, OFF_IRQ_STAT, OFF_IRQ_MASK}) ? RESP_OKAY : RESP_SLVERR;
    endfunction : resp_of

    // Holds each channel until its own ready, then waits for the response
    task automatic handshake(input bit is_rd);
        int n;
        for (n = 0; n < 200; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (arready) arvalid <= 1'b0;
            if (is_rd ? rvalid : bvalid) break;
        end
        if (is_rd) rready <= 1'b0;
        else bready <= 1'b0;
        if (n == 200) begin
            fail("bus response timeout");
            complete_run();
        end
    endtask : handshake

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= {a, 2'b00};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        exp_q.push_back({1'b0, resp_of(a), 32'h0000_0000});
        handshake(1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        araddr <= {a, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        exp_q.push_back({1'b1, resp_of(a), 24'h00_0000, d});
        handshake(1'b1);
    endtask : rd

    // Scoreboard: oldest note against each response
    always @(posedge clk) begin
        if (!rst && ((rvalid && rready) || (bvalid && bready))) begin
            if (exp_q.size() == 0) fail("response with no note");
            else begin
                exp_e = exp_q.pop_front();
                compares++;
                if (exp_e[34] ? ({rresp, rdata} !== exp_e[33:0]) : (bresp !== exp_e[33:32]))
                    fail("bus response mismatch");
            end
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        fail("run timeout");
        complete_run();
    end

    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'h1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_CONTROL, RST_BYTE);
        rd(OFF_MODE, RST_BYTE);
        for (i = 0; i < 4; i++) rd(cnt_off[i], RST_BYTE);
        rd(8'h80, 8'h00);
        wr(8'h80, 8'h5a);
        for (i = 0; i < 4; i++) begin
            rb = 8'($random(seed));
            wr(cnt_off[i], rb);
            rd(cnt_off[i], rb);
        end
        for (i = 0; i < 2; i++) begin
            lo = i ? OFF_ONE_LOW : OFF_ZERO_LOW;
            hi = i ? OFF_ONE_HIGH : OFF_ZERO_HIGH;
            sh = i ? 4 : 0;
            run = i ? 8'h40 : 8'h10;
            flg = i ? 8'h80 : 8'h20;
            ak = dtc_ack_t'(i ? 4'h8 : 4'h4);
            wr(OFF_CONTROL, 8'h00);
            wr(OFF_MODE, 8'h05 << sh);
            wr(lo, 8'hfe);
            wr(hi, 8'hff);
            u_dtc_partner.pulse(i, 3);
            rd(lo, 8'hfe);
            wr(OFF_CONTROL, run);
            u_dtc_partner.pulse(i, 3);
            rd(lo, 8'h01);
            rd(hi, 8'h00);
            rd(OFF_CONTROL, run | flg);
            u_dtc_partner.ack(ak);
            rd(OFF_CONTROL, run);
            wr(OFF_CONTROL, 8'h00);
            wr(OFF_MODE, 8'h04 << sh);
            wr(lo, 8'hfe);
            wr(hi, 8'hff);
            wr(OFF_CONTROL, run);
            u_dtc_partner.pulse(i, 2);
            rd(lo, 8'he0);
            rd(hi, 8'h00);
            rd(OFF_CONTROL, run | flg);
            wr(OFF_CONTROL, 8'h00);
            wr(OFF_MODE, 8'h06 << sh);
            wr(lo, 8'hff);
            wr(hi, 8'h80);
            wr(OFF_CONTROL, run);
            u_dtc_partner.pulse(i, 1);
            rd(lo, 8'h80);
            rd(OFF_CONTROL, run | flg);
            wr(OFF_CONTROL, 8'h00);
            wr(OFF_MODE, 8'h09 << sh);
            u_dtc_partner.level(i, 1'b0, 6);
            wr(lo, 8'h00);
            wr(hi, 8'h00);
            wr(OFF_CONTROL, run);
            u_dtc_partner.level(i, 1'b1, 40);
            u_dtc_partner.level(i, 1'b0, 6);
            rd(lo, 8'h14);
            rd(hi, 8'h00);
            u_dtc_partner.level(i, 1'b1, 6);
        end
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_MODE, 8'h77);
        wr(OFF_ZERO_LOW, 8'hfe);
        wr(OFF_ZERO_HIGH, 8'hff);
        wr(OFF_ONE_LOW, 8'h05);
        wr(OFF_CONTROL, 8'h50);
        u_dtc_partner.pulse(0, 3);
        u_dtc_partner.pulse(1, 3);
        rd(OFF_ZERO_LOW, 8'h01);
        rd(OFF_ONE_LOW, 8'h05);
        rd(OFF_CONTROL, 8'hf0);
        wr(OFF_CONTROL, 8'h00);
        for (i = 0; i < 2; i++) begin
            typ = i ? 8'h04 : 8'h01;
            flg = i ? 8'h08 : 8'h02;
            ak = dtc_ack_t'(i ? 4'h2 : 4'h1);
            wr(OFF_CONTROL, typ);
            u_dtc_partner.level(i, 1'b0, 6);
            rd(OFF_CONTROL, typ | flg);
            chk(i ? req1 : req0, 1'b1);
            u_dtc_partner.ack(ak);
            rd(OFF_CONTROL, typ);
            u_dtc_partner.level(i, 1'b1, 6);
            wr(OFF_CONTROL, 8'h00);
            u_dtc_partner.level(i, 1'b0, 6);
            u_dtc_partner.ack(ak);
            rd(OFF_CONTROL, flg);
            u_dtc_partner.level(i, 1'b1, 6);
            u_dtc_partner.ack(ak);
            rd(OFF_CONTROL, 8'h00);
        end
        rd(OFF_IRQ_STAT, 8'h0f);
        chk(irq, 1'b0);
        wr(OFF_IRQ_MASK, 8'h04);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        wr(OFF_IRQ_STAT, 8'h04);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        rd(OFF_IRQ_STAT, 8'h0b);
        rd(OFF_IRQ_MASK, 8'h04);
        repeat (2) @(posedge clk);
        complete_run();
    end
endmodule : testbench
